// File: core/dlm_datapath.sv
// Load, multiply-accumulate and max/min select datapath of the DSP coprocessor.
module dlm_datapath
	import dlm_pkg::*;
#(
	parameter int PTR_WIDTH = PTR_W
)
(
	// Clock and reset.
	input wire logic MCLK,
	input wire logic RST_N,
	// Decoded instruction from the host core.
	input wire logic OP_VALID,
	input wire dlm_op_e OP_CODE,
	input wire dlm_src_e OP_SRC,
	input wire dlm_move_e OP_MOVE,
	input wire logic [1:0] OP_ACC,
	input wire logic [1:0] OP_ACC_SRC,
	input wire logic [2:0] OP_DST,
	input wire logic [2:0] OP_REG,
	input wire logic OP_MAC,
	input wire logic OP_XSEL,
	input wire logic OP_YSEL,
	input wire logic OP_IMM_SHORT,
	input wire logic OP_LONG,
	input wire logic [HALF_W-1:0] OP_IMM,
	input wire logic [HALF_W-1:0] HOST_REG,
	// Data memory operands and pointer history.
	input wire logic [ACC_W-1:0] MEM_X_DATA,
	input wire logic [ACC_W-1:0] MEM_Y_DATA,
	input wire logic [PTR_WIDTH-1:0] PREV_ADDR,
	// Register port.
	input wire logic [BUS_AW-1:0] ADDR,
	input wire logic [BUS_DW-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [BUS_DW-1:0] RDATA,
	// Store path and instruction length.
	output logic STORE_VALID,
	output logic [ACC_W-1:0] STORE_DATA,
	output logic [1:0] OP_WORDS,
	// Flags and captured index.
	output logic [PTR_WIDTH-1:0] INDEX_CAPTURE_POINTER,
	output logic FLAG_C,
	output logic FLAG_Z,
	output logic FLAG_V,
	output logic FLAG_N,
	output logic FLAG_VM0,
	output logic FLAG_VM1,
	output logic FLAG_STICKY
);

	// General registers: 0-3 accumulators, 4-5 X operands, 6-7 Y operands.
	logic [ACC_W-1:0] gr [0:GREG_N-1];
	logic [ACC_W-1:0] next_gr [0:GREG_N-1];
	logic [PROD_W-1:0] prod_reg;
	logic [PROD_W-1:0] next_prod;
	logic [MAC_W-1:0] ma [0:1];
	logic [MAC_W-1:0] next_ma [0:1];
	logic flag_c;
	logic flag_z;
	logic flag_v;
	logic flag_n;
	logic [1:0] vm;
	logic sticky_ovf;
	logic next_c;
	logic next_z;
	logic next_v;
	logic next_n;
	logic [1:0] next_vm;
	logic next_sticky;
	logic [PTR_WIDTH-1:0] index_ptr;
	logic [PTR_WIDTH-1:0] next_index;
	logic store_valid;
	logic [ACC_W-1:0] store_data;
	logic next_store_valid;
	logic [ACC_W-1:0] next_store_data;
	logic [1:0] words;
	logic [BUS_DW-1:0] rdata;
	logic [BUS_DW-1:0] rd_word;

	// Operand helpers.
	logic [ACC_W-1:0] imm_ext;
	logic [ACC_W-1:0] acc_load;
	logic [ACC_W-1:0] gen_load;
	logic signed [PROD_W-1:0] product;
	logic [MAC_W-1:0] prod_ext;
	logic [MAC_W-1:0] hi_src;
	logic [ACC_W-1:0] hi_val;
	logic hi_ovf;
	logic [ACC_W-1:0] lhs;
	logic [ACC_W-1:0] rhs;
	logic [ACC_W:0] diff;
	logic cmp_v;
	logic cmp_n;
	logic cmp_z;
	logic cmp_take;
	logic is_min;
	logic has_move;
	logic [MAC_W-1:0] mac_sum;
	logic mac_into_guard;
	logic mac_wrap;

	// Register file index of accumulator k.
	function automatic logic [2:0] acc_idx(input logic [1:0] k);
		return {1'b0, k};
	endfunction

	// Immediates are right-aligned and sign-extended from 5 or 16 bits.
	assign imm_ext = OP_IMM_SHORT
		? {{(ACC_W-SHORT_IMM_W){OP_IMM[SHORT_IMM_W-1]}},
			OP_IMM[SHORT_IMM_W-1:0]} // RL1 RL9
		: {{(ACC_W-HALF_W){OP_IMM[HALF_W-1]}}, OP_IMM}; // RL1 RL9

	// Signed product of the selected operands, read before this cycle's loads.
	assign product = $signed(gr[{2'b10, OP_XSEL}])
		* $signed(gr[{2'b11, OP_YSEL}]); // RL12 RL22
	assign prod_ext = {{(MAC_W-PROD_W){prod_reg[PROD_W-1]}}, prod_reg}; // RL8

	// One adder serves every multiply-accumulate form.
	dlm_mac_adder u_mac_adder (
		.augend(ma[OP_MAC]),
		.addend(prod_ext),
		.sum(mac_sum),
		.into_guard(mac_into_guard),
		.guard_wrap(mac_wrap)
	);

	// Source of an accumulator load; a host register is zero-extended.
	always_comb
	begin
		case (OP_SRC)
			SRC_IMM: acc_load = imm_ext;
			SRC_HOST16: acc_load = {{(ACC_W-HALF_W){1'b0}}, HOST_REG}; // RL2
			SRC_GREG: acc_load = gr[acc_idx(OP_ACC_SRC)];
			default: acc_load = MEM_X_DATA;
		endcase
	end

	// Source of a general move; wide sources give their low part.
	always_comb
	begin
		case (OP_SRC)
			SRC_IMM: gen_load = imm_ext;
			SRC_HOST16: gen_load = {{(ACC_W-HALF_W){1'b0}}, HOST_REG};
			SRC_GREG: gen_load = gr[OP_REG];
			SRC_PROD: gen_load = prod_reg[ACC_W-1:0]; // RL9
			default: gen_load = MEM_X_DATA;
		endcase
	end

	// Upper accumulator slice for moves, with the optional one-bit shift.
	always_comb
	begin
		hi_src = (OP_CODE == LOAD_MOVE_OP_ACC_MAC) ? ma[OP_MAC] : ma[~OP_MAC];
		hi_ovf = guard_ovf(hi_src);
		case (OP_MOVE)
			MAC_HIGH_SHIFT_RIGHT:
				hi_val = {hi_src[MAC_HI_MSB],
					hi_src[MAC_HI_MSB:MAC_HI_LSB+1]}; // RL15
			MAC_HIGH_SHIFT_LEFT:
			begin
				hi_val = {hi_src[MAC_HI_MSB-1:MAC_HI_LSB], 1'b0}; // RL15
				hi_ovf = hi_ovf | (hi_src[MAC_HI_MSB] ^ hi_src[MAC_HI_MSB-1]);
			end
			default: hi_val = hi_src[MAC_HI_MSB:MAC_HI_LSB]; // RL6 RL15
		endcase
	end

	// Compare for max/min select; the result sign is V xor the result MSB.
	always_comb
	begin
		is_min = (OP_CODE == MIN_SELECT_OP) || (OP_CODE == MIN_SELECT_OP_MOVE);
		if (is_min)
		begin
			lhs = gr[acc_idx(OP_ACC_SRC)]; // RL21
			rhs = gr[acc_idx(OP_ACC)];
		end
		else
		begin
			lhs = gr[acc_idx(OP_ACC)]; // RL19
			rhs = gr[acc_idx(OP_ACC_SRC)];
		end
		diff = {1'b0, lhs} + {1'b0, ~rhs} + CMP_ONE;
		cmp_v = (lhs[ACC_W-1] ^ rhs[ACC_W-1])
			& (diff[ACC_W-1] ^ lhs[ACC_W-1]);
		cmp_n = cmp_v ^ diff[ACC_W-1]; // RL19
		cmp_z = (diff[ACC_W-1:0] == ACC_ZERO);
		// Difference not above zero means the operand wins in both cases.
		cmp_take = cmp_n | cmp_z; // RL18 RL21
	end

	// Read mux of the register port; unmapped offsets read zero.
	always_comb
	begin
		rd_word = BUS_ZERO;
		if (ADDR <= REG_GREG_LAST)
			rd_word = BUS_DW'(gr[ADDR[2:0]]);
		else
		begin
			case (ADDR)
				REG_P_LO: rd_word = BUS_DW'(prod_reg[ACC_W-1:0]);
				REG_P_HI: rd_word = BUS_DW'(prod_reg[PROD_W-1:ACC_W]);
				REG_MA0_LO: rd_word = ma[0][BUS_DW-1:0];
				REG_MA0_HI: rd_word = BUS_DW'(ma[0][MAC_W-1:BUS_DW]);
				REG_MA1_LO: rd_word = ma[1][BUS_DW-1:0];
				REG_MA1_HI: rd_word = BUS_DW'(ma[1][MAC_W-1:BUS_DW]);
				REG_FLAGS: rd_word = BUS_DW'({sticky_ovf, vm, flag_n,
					flag_v, flag_z, flag_c});
				REG_INDEX: rd_word = BUS_DW'(index_ptr);
				default: rd_word = BUS_ZERO;
			endcase
		end
	end

	// Next state of all but the read data and the length. Every source is a register value
	// from before this instruction, so the accumulate sees the old product.
	// A port write comes first and the instruction overrides it.
	always_comb
	begin
		next_gr = gr;
		next_prod = prod_reg;
		next_ma = ma;
		next_c = flag_c;
		next_z = flag_z;
		next_v = flag_v;
		next_n = flag_n;
		next_vm = vm;
		next_sticky = sticky_ovf;
		next_index = index_ptr;
		next_store_valid = 1'b0;
		next_store_data = store_data;
		has_move = 1'b0;
		if (WR)
		begin
			if (ADDR <= REG_GREG_LAST)
				next_gr[ADDR[2:0]] = WDATA[ACC_W-1:0];
			else if (ADDR == REG_FLAGS)
			begin
				next_c = WDATA[FLAG_C_BIT];
				next_z = WDATA[FLAG_Z_BIT];
				next_v = WDATA[FLAG_V_BIT];
				next_n = WDATA[FLAG_N_BIT];
				next_vm = {WDATA[FLAG_VM1_BIT], WDATA[FLAG_VM0_BIT]};
				next_sticky = WDATA[FLAG_STICKY_BIT];
			end
		end
		if (OP_VALID)
		begin
			case (OP_CODE)
				LOAD_MOVE_OP_ACC:
				begin
					next_gr[acc_idx(OP_ACC)] = acc_load;
					if (OP_SRC != SRC_MEM) // RL4
					begin
						next_z = (acc_load == ACC_ZERO); // RL3
						next_v = 1'b0; // RL3
						next_n = acc_load[ACC_W-1]; // RL3
					end
				end
				LOAD_MOVE_OP_ACC_MAC:
				begin
					next_gr[acc_idx(OP_ACC)] = hi_val; // RL6
					next_z = (hi_val == ACC_ZERO);
					next_v = hi_ovf;
					next_n = hi_val[ACC_W-1];
					has_move = 1'b1; // RL6
				end
				LOAD_MOVE_OP_MAC_MAC:
				begin
					next_ma[OP_MAC] = ma[~OP_MAC]; // RL7
					next_vm[OP_MAC] = guard_ovf(ma[~OP_MAC]); // RL7 RL13
				end
				LOAD_MOVE_OP_MAC_PROD:
				begin
					next_ma[OP_MAC] = prod_ext; // RL8
					next_vm[OP_MAC] = guard_ovf(prod_ext); // RL13
					has_move = 1'b1; // RL8
				end
				LOAD_MOVE_OP_GENERAL:
					next_gr[OP_DST] = gen_load; // RL9
				LOAD_MOVE_OP_DOUBLE:
				begin
					next_gr[{2'b10, OP_XSEL}] = MEM_X_DATA; // RL11
					next_gr[{2'b11, OP_YSEL}] = MEM_Y_DATA; // RL11
				end
				MULTIPLY_ACCUMULATE_OP,
				MULTIPLY_ACCUMULATE_OP_MOVE,
				MULTIPLY_ACCUMULATE_OP_DOUBLE:
				begin
					next_ma[OP_MAC] = mac_sum; // RL12
					next_prod = product; // RL12
					next_vm[OP_MAC] = mac_into_guard; // RL13
					if (mac_wrap)
						next_sticky = 1'b1; // RL14
					has_move = (OP_CODE == MULTIPLY_ACCUMULATE_OP_MOVE);
					if (OP_CODE == MULTIPLY_ACCUMULATE_OP_DOUBLE)
					begin
						next_gr[{2'b10, OP_XSEL}] = MEM_X_DATA; // RL17
						next_gr[{2'b11, OP_YSEL}] = MEM_Y_DATA; // RL17
					end
				end
				MAX_SELECT_OP,
				MAX_SELECT_OP_MOVE,
				MIN_SELECT_OP,
				MIN_SELECT_OP_MOVE:
				begin
					next_c = diff[ACC_W]; // RL19 RL21
					next_z = cmp_z; // RL19 RL21
					next_v = cmp_v; // RL19 RL21
					next_n = cmp_n; // RL19 RL21
					if (cmp_take)
					begin
						next_gr[acc_idx(OP_ACC)] = gr[acc_idx(OP_ACC_SRC)]; // RL18
						next_index = PREV_ADDR; // RL18 RL21
					end
					// The compared register reloads from memory in any case.
					if (OP_CODE == MAX_SELECT_OP_MOVE
						|| OP_CODE == MIN_SELECT_OP_MOVE)
						next_gr[acc_idx(OP_ACC_SRC)] = MEM_X_DATA; // RL20
				end
				default:
				begin
					next_index = index_ptr;
				end
			endcase
			if (has_move)
			begin
				case (OP_MOVE)
					MOVE_MEM_TO_REG:
						next_gr[OP_REG] = MEM_X_DATA;
					MOVE_MAC_HIGH,
					MAC_HIGH_SHIFT_RIGHT,
					MAC_HIGH_SHIFT_LEFT:
					begin
						next_gr[acc_idx(OP_ACC)] = hi_val; // RL15
						next_z = (hi_val == ACC_ZERO); // RL16
						next_v = hi_ovf; // RL16
						next_n = hi_val[ACC_W-1]; // RL16
					end
					MOVE_STORE_REG:
					begin
						next_store_valid = 1'b1;
						next_store_data = gr[OP_REG];
					end
					MOVE_STORE_PROD:
					begin
						next_store_valid = 1'b1;
						next_store_data = prod_reg[PROD_W-1:ACC_W];
					end
					default:
					begin
						next_store_valid = 1'b0;
					end
				endcase
			end
		end
	end

	// General registers.
	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
		begin
			for (int k = 0; k < GREG_N; k++)
				gr[k] <= ACC_ZERO;
		end
		else
			gr <= next_gr;
	end

	// Product register and mac accumulators.
	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
		begin
			prod_reg <= PROD_ZERO;
			ma[0] <= MAC_ZERO;
			ma[1] <= MAC_ZERO;
		end
		else
		begin
			prod_reg <= next_prod;
			ma <= next_ma;
		end
	end

	// Flags; the sticky flag is set by hardware after a port clear.
	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
		begin
			flag_c <= 1'b0;
			flag_z <= 1'b0;
			flag_v <= 1'b0;
			flag_n <= 1'b0;
			vm <= 2'h0;
			sticky_ovf <= 1'b0;
		end
		else
		begin
			flag_c <= next_c;
			flag_z <= next_z;
			flag_v <= next_v;
			flag_n <= next_n;
			vm <= next_vm;
			sticky_ovf <= next_sticky;
		end
	end

	// Index capture pointer and store path.
	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
		begin
			index_ptr <= PTR_WIDTH'(PTR_ZERO);
			store_valid <= 1'b0;
			store_data <= ACC_ZERO;
		end
		else
		begin
			index_ptr <= next_index;
			store_valid <= next_store_valid;
			store_data <= next_store_data;
		end
	end

	// Length of the last accepted instruction, for the fetch logic.
	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
			words <= WORDS_ONE;
		else if (OP_VALID)
		begin
			if (OP_LONG && (OP_CODE == LOAD_MOVE_OP_ACC
				|| OP_CODE == LOAD_MOVE_OP_GENERAL))
				words <= WORDS_TWO; // RL5 RL10
			else
				words <= WORDS_ONE; // RL5 RL10
		end
	end

	// Read data stands only in the cycle after the read strobe.
	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
			rdata <= BUS_ZERO;
		else if (RD)
			rdata <= rd_word;
		else
			rdata <= BUS_ZERO;
	end

	// Outputs straight from their flip-flops.
	assign RDATA = rdata;
	assign STORE_VALID = store_valid;
	assign STORE_DATA = store_data;
	assign OP_WORDS = words;
	assign INDEX_CAPTURE_POINTER = index_ptr;
	assign FLAG_C = flag_c;
	assign FLAG_Z = flag_z;
	assign FLAG_V = flag_v;
	assign FLAG_N = flag_n;
	assign FLAG_VM0 = vm[0];
	assign FLAG_VM1 = vm[1];
	assign FLAG_STICKY = sticky_ovf;

endmodule // dlm_datapath

// File: core/dlm_pkg.sv
// Constants, types and helpers of the DSP load, multiply-accumulate datapath.
//
// Operation
// RL1: Immediate loads to an accumulator are right-aligned and sign-extended to 24 bits.
// RL2: A 16-bit register source loaded into an accumulator is zero-extended.
// RL3: Register or immediate accumulator loads set zero, overflow, negative flags.
// RL4: Accumulator loads from data memory leave zero, overflow, negative unchanged.
// RL5: Accumulator load takes two words with 16-bit address or immediate.
// RL6: Accumulator takes the mac accumulator upper 24 bits plus one move.
// RL7: One mac accumulator copies the other whole; guard flag follows.
// RL8: Mac accumulator loads sign-extended 48-bit product, plus one move.
// RL9: General moves sign-extend narrow immediates and keep low part of wide sources.
// RL10: General move takes two words with 16-bit address or immediate.
// RL11: Double load fills X and Y operand registers from two memories.
// RL12: Multiply-accumulate adds product to accumulator and multiplies X by Y.
// RL13: Each mac accumulator write sets or clears its own guard flag.
// RL14: Multiply-accumulate sets the sticky guard flag, never clears it.
// RL15: One-move form loads accumulator from other mac high bits, shifted or not.
// RL16: Accumulator target of a multiply-accumulate move updates zero, overflow, negative.
// RL17: Two-move form also loads X and Y operands from memory.
// RL18: Max-load copies operand and captures pointer when operand not below.
// RL19: Max-load flags come from accumulator minus operand; negative is V xor MSB.
// RL20: Software never uses the index capture pointer for the parallel move.
// RL21: Min-load copies when operand not above; flags from operand minus accumulator.
// RL22: All parts of one instruction read the values from before it.
package dlm_pkg;

	localparam int ACC_W = 24;
	localparam int MAC_W = 52;
	localparam int PROD_W = 48;
	localparam int HALF_W = 16;
	localparam int SHORT_IMM_W = 5;
	localparam int PTR_W = 16;
	localparam int BUS_AW = 5;
	localparam int BUS_DW = 32;
	localparam int GREG_N = 8;
	localparam int GUARD_LSB = 47;
	localparam int MAC_HI_MSB = 47;
	localparam int MAC_HI_LSB = 24;

	// Register port offsets; 0 to 7 address the general registers.
	localparam logic [4:0] REG_GREG_LAST = 5'h07;
	localparam logic [4:0] REG_P_LO = 5'h08;
	localparam logic [4:0] REG_P_HI = 5'h09;
	localparam logic [4:0] REG_MA0_LO = 5'h0A;
	localparam logic [4:0] REG_MA0_HI = 5'h0B;
	localparam logic [4:0] REG_MA1_LO = 5'h0C;
	localparam logic [4:0] REG_MA1_HI = 5'h0D;
	localparam logic [4:0] REG_FLAGS = 5'h0E;
	localparam logic [4:0] REG_INDEX = 5'h0F;

	// Bit positions in the flag register.
	localparam int FLAG_C_BIT = 0;
	localparam int FLAG_Z_BIT = 1;
	localparam int FLAG_V_BIT = 2;
	localparam int FLAG_N_BIT = 3;
	localparam int FLAG_VM0_BIT = 4;
	localparam int FLAG_VM1_BIT = 5;
	localparam int FLAG_STICKY_BIT = 6;

	// Values after reset and fixed constants.
	localparam logic [ACC_W-1:0] ACC_ZERO = 24'h00_0000;
	localparam logic [MAC_W-1:0] MAC_ZERO = 52'h0_0000_0000_0000;
	localparam logic [PROD_W-1:0] PROD_ZERO = 48'h0000_0000_0000;
	localparam logic [PTR_W-1:0] PTR_ZERO = 16'h0000;
	localparam logic [BUS_DW-1:0] BUS_ZERO = 32'h0000_0000;
	localparam logic [ACC_W:0] CMP_ONE = 25'h000_0001;
	localparam logic [1:0] WORDS_ONE = 2'h1;
	localparam logic [1:0] WORDS_TWO = 2'h2;

	typedef enum logic [3:0] {
		DLM_NOP,
		LOAD_MOVE_OP_ACC,
		LOAD_MOVE_OP_ACC_MAC,
		LOAD_MOVE_OP_MAC_MAC,
		LOAD_MOVE_OP_MAC_PROD,
		LOAD_MOVE_OP_GENERAL,
		LOAD_MOVE_OP_DOUBLE,
		MULTIPLY_ACCUMULATE_OP,
		MULTIPLY_ACCUMULATE_OP_MOVE,
		MULTIPLY_ACCUMULATE_OP_DOUBLE,
		MAX_SELECT_OP,
		MAX_SELECT_OP_MOVE,
		MIN_SELECT_OP,
		MIN_SELECT_OP_MOVE
	} dlm_op_e;

	typedef enum logic [2:0] {
		SRC_MEM,
		SRC_IMM,
		SRC_HOST16,
		SRC_GREG,
		SRC_PROD
	} dlm_src_e;

	typedef enum logic [2:0] {
		MOVE_NONE,
		MOVE_MEM_TO_REG,
		MOVE_MAC_HIGH,
		MAC_HIGH_SHIFT_RIGHT,
		MAC_HIGH_SHIFT_LEFT,
		MOVE_STORE_REG,
		MOVE_STORE_PROD
	} dlm_move_e;

	// True when the guard bits are not a sign extension of bit 47.
	function automatic logic guard_ovf(input logic [MAC_W-1:0] v);
		return !((&v[MAC_W-1:GUARD_LSB]) || !(|v[MAC_W-1:GUARD_LSB]));
	endfunction

endpackage

// File: core/dlm_mac_adder.sv
// Guarded 52-bit adder of the multiply-accumulate path.
module dlm_mac_adder
	import dlm_pkg::*;
(
	// Operands.
	input wire logic [MAC_W-1:0] augend,
	input wire logic [MAC_W-1:0] addend,
	// Result and overflow indications.
	output logic [MAC_W-1:0] sum,
	output logic into_guard,
	output logic guard_wrap
);

	// Guard wrap is plain two's complement overflow of the full width.
	always_comb
	begin
		sum = augend + addend;
		into_guard = guard_ovf(sum);
		guard_wrap = (augend[MAC_W-1] == addend[MAC_W-1])
			&& (sum[MAC_W-1] != augend[MAC_W-1]);
	end

endmodule // dlm_mac_adder

// File: verification/dlm_mem_model.sv
// Data memory and pointer model that feeds the datapath's operand inputs.
module dlm_mem_model
	import dlm_pkg::*;
(
	// Clock and pointer from the issuing side.
	input wire logic MCLK,
	input wire logic [7:0] PTR,
	// Operands and pointer history.
	output logic [ACC_W-1:0] MEM_X_DATA,
	output logic [ACC_W-1:0] MEM_Y_DATA,
	output logic [PTR_W-1:0] PREV_ADDR
);
	// Every word is a pattern of its address, so a stale operand shows up.
	assign MEM_X_DATA = {PTR, ~PTR, PTR};
	assign MEM_Y_DATA = {~PTR, PTR, 8'h5A};

	// The last address trails the pointer by one cycle; this pointer is
	// what the index capture pointer takes on a select.
	always_ff @(posedge MCLK)
		PREV_ADDR <= {8'h00, PTR};
endmodule // dlm_mem_model

// File: verification/dlm_datapath_sva.sv
// Port-level assertion checker of the load and multiply-accumulate datapath.
module dlm_datapath_sva
	import dlm_pkg::*;
#(
	parameter int PTR_WIDTH = PTR_W
)
(
	// Clock and reset.
	input wire logic MCLK,
	input wire logic RST_N,
	// Instruction inputs.
	input wire logic OP_VALID,
	input wire dlm_op_e OP_CODE,
	input wire dlm_src_e OP_SRC,
	input wire logic OP_IMM_SHORT,
	input wire logic OP_LONG,
	input wire logic [HALF_W-1:0] OP_IMM,
	input wire logic [HALF_W-1:0] HOST_REG,
	// Register port.
	input wire logic [BUS_AW-1:0] ADDR,
	input wire logic WR,
	// Results.
	input wire logic [1:0] OP_WORDS,
	input wire logic [PTR_WIDTH-1:0] INDEX_CAPTURE_POINTER,
	input wire logic FLAG_Z,
	input wire logic FLAG_V,
	input wire logic FLAG_N,
	input wire logic FLAG_STICKY
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_N);

	// A port write to the flags may override, so it is excluded where needed.
	logic acc_ld, fl_wr, sel_op;
	assign acc_ld = OP_VALID && OP_CODE == LOAD_MOVE_OP_ACC;
	assign fl_wr = WR && ADDR == REG_FLAGS;
	assign sel_op = OP_VALID && OP_CODE inside {MAX_SELECT_OP,
		MAX_SELECT_OP_MOVE, MIN_SELECT_OP, MIN_SELECT_OP_MOVE};

	AST_WORDS_LONG: assert property (acc_ld && OP_LONG
		|=> OP_WORDS == WORDS_TWO) else $error("long load not two words");
	AST_WORDS_SHORT: assert property (acc_ld && !OP_LONG
		|=> OP_WORDS == WORDS_ONE) else $error("short load not one word");
	AST_WORDS_GEN: assert property (OP_VALID &&
		OP_CODE == LOAD_MOVE_OP_GENERAL |=> OP_WORDS ==
		($past(OP_LONG) ? WORDS_TWO : WORDS_ONE))
		else $error("general move length wrong");
	AST_MEM_FLAGS: assert property (acc_ld && OP_SRC == SRC_MEM
		&& !fl_wr |=> $stable({FLAG_Z, FLAG_V, FLAG_N}))
		else $error("memory load changed flags");
	AST_IMM_FLAGS: assert property (acc_ld && OP_SRC == SRC_IMM
		&& !OP_IMM_SHORT |=> FLAG_N == $past(OP_IMM[15]) && !FLAG_V
		&& FLAG_Z == ($past(OP_IMM) == 16'h0000))
		else $error("immediate load flags wrong");
	AST_SHORT_SIGN: assert property (acc_ld && OP_SRC == SRC_IMM
		&& OP_IMM_SHORT |=> FLAG_N == $past(OP_IMM[4]))
		else $error("short immediate sign wrong");
	AST_HOST_ZEXT: assert property (acc_ld
		&& OP_SRC == SRC_HOST16 |=> !FLAG_N
		&& FLAG_Z == ($past(HOST_REG) == 16'h0000))
		else $error("host register load flags wrong");
	AST_STICKY_HOLD: assert property (FLAG_STICKY && !fl_wr
		|=> FLAG_STICKY) else $error("sticky guard flag cleared");
	AST_INDEX_CAUSE: assert property (!$stable(INDEX_CAPTURE_POINTER)
		|-> $past(sel_op)) else $error("index changed without select");

	// Main scenarios.
	COV_SELECT: cover property (sel_op);
	COV_LONG: cover property (acc_ld && OP_LONG);
	COV_MAC: cover property (OP_VALID && OP_CODE == MULTIPLY_ACCUMULATE_OP);
endmodule // dlm_datapath_sva

bind dlm_datapath dlm_datapath_sva #(.PTR_WIDTH(PTR_WIDTH)) u_sva (.MCLK,
	.RST_N, .OP_VALID, .OP_CODE, .OP_SRC, .OP_IMM_SHORT, .OP_LONG, .OP_IMM,
	.HOST_REG, .ADDR, .WR, .OP_WORDS, .INDEX_CAPTURE_POINTER, .FLAG_Z,
	.FLAG_V, .FLAG_N, .FLAG_STICKY);

// File: verification/dlm_datapath_tb_top.sv
// Self-checking bench of the load and multiply-accumulate datapath.
module dlm_datapath_tb_top
	import dlm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic MCLK = 1'b0, RST_N = 1'b0, OP_VALID = 1'b0;
	dlm_op_e OP_CODE = DLM_NOP;
	dlm_src_e OP_SRC = SRC_MEM;
	dlm_move_e OP_MOVE = MOVE_NONE;
	logic [1:0] OP_ACC = 2'h0, OP_ACC_SRC = 2'h0;
	logic [2:0] OP_DST = 3'h0, OP_REG = 3'h0;
	logic OP_MAC = 1'b0, OP_XSEL = 1'b0, OP_YSEL = 1'b0;
	logic OP_IMM_SHORT = 1'b0, OP_LONG = 1'b0, WR = 1'b0, RD = 1'b0;
	logic [15:0] OP_IMM = 16'h0000, HOST_REG = 16'h0000;
	logic [4:0] ADDR = 5'h00;
	logic [31:0] WDATA = 32'h0000_0000, RDATA;
	logic [7:0] ptr = 8'h00;
	logic [23:0] STORE_DATA, MEM_X_DATA, MEM_Y_DATA, e24;
	logic [1:0] OP_WORDS;
	logic [15:0] INDEX_CAPTURE_POINTER, PREV_ADDR;
	logic STORE_VALID, FLAG_C, FLAG_Z, FLAG_V, FLAG_N, FLAG_VM0, FLAG_VM1;
	logic FLAG_STICKY, rd_seen = 1'b0;
	logic [31:0] seed = 32'h0001_2C0D;
	logic [31:0] exp_q[$];
	int fails = 0, total_checks = 0;

	dlm_mem_model u_mem (.MCLK, .PTR(ptr), .MEM_X_DATA, .MEM_Y_DATA,
		.PREV_ADDR);
	dlm_datapath u_dut (.*);

	always #5 MCLK = ~MCLK;

	// The generator starts at 76813 so every run sees the same values.
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		// A note that no result ever arrived to check counts as a mismatch.
		if (exp_q.size() != 0)
			fails++;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Strobes stay up between calls so that no signal is set twice at once.
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		{ADDR, WDATA, RD, WR} <= {a, d, 2'b01};
		@(posedge MCLK);
	endtask

	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		{ADDR, RD, WR} <= {a, 2'b10};
		exp_q.push_back(e);
		@(posedge MCLK);
	endtask

	// Issues n back-to-back instructions, then leaves one idle cycle.
	task automatic go(input int n);
		{OP_VALID, RD, WR} <= 3'b100;
		repeat (n) @(posedge MCLK);
		OP_VALID <= 1'b0;
		@(posedge MCLK);
	endtask

	// Oldest expected result, or unknown when none is waiting.
	function automatic logic [31:0] next_note();
		return exp_q.size() ? exp_q.pop_front() : 32'hxxxx_xxxx;
	endfunction

	// Read data and store pulses stand one cycle, so look in that cycle.
	always @(posedge MCLK)
		rd_seen <= RD && RST_N;
	always @(negedge MCLK)
	begin
		if (rd_seen)
			check(RDATA, next_note());
		if (STORE_VALID)
			check({8'h00, STORE_DATA}, next_note());
	end

	// Guards against a hang anywhere in the sequence.
	initial
	begin
		repeat (2000) @(posedge MCLK);
		fails++;
		print_verdict();
	end

	initial
	begin
		repeat (3) @(posedge MCLK);
		RST_N <= 1'b1;
		ptr <= 8'h80;
		OP_CODE <= LOAD_MOVE_OP_ACC;
		OP_SRC <= SRC_IMM;
		for (int i = 0; i < 4; i++)
		begin
			seed = lfsr(seed);
			OP_ACC <= i[1:0];
			OP_IMM <= seed[15:0];
			OP_IMM_SHORT <= i[0];
			OP_LONG <= !i[0];
			e24 = i[0] ? {{19{seed[4]}}, seed[4:0]} : {{8{seed[15]}}, seed[15:0]};
			go(1);
			rd(i[4:0], {8'h00, e24});
			rd(REG_FLAGS, {28'h000_0000, e24[23], 1'b0,
				e24 == ACC_ZERO, 1'b0});
		end
		OP_SRC <= SRC_HOST16;
		OP_ACC <= 2'h1;
		HOST_REG <= 16'h8000;
		go(1);
		rd(5'h01, 32'h0000_8000);
		rd(REG_FLAGS, 32'h0000_0000);
		OP_SRC <= SRC_MEM;
		OP_ACC <= 2'h2;
		go(1);
		rd(5'h02, {8'h00, MEM_X_DATA});
		rd(REG_FLAGS, 32'h0000_0000);
		OP_CODE <= LOAD_MOVE_OP_GENERAL;
		OP_SRC <= SRC_IMM;
		OP_DST <= 3'h4;
		OP_IMM <= 16'h8001;
		OP_IMM_SHORT <= 1'b0;
		OP_LONG <= 1'b1;
		go(1);
		rd(5'h04, 32'h00FF_8001);
		wr(5'h04, 32'h0000_0003);
		wr(5'h06, 32'h00FF_FFFE);
		wr(REG_FLAGS, 32'h0000_0040);
		OP_CODE <= MULTIPLY_ACCUMULATE_OP;
		go(2);
		rd(REG_MA0_LO, 32'hFFFF_FFFA);
		rd(REG_MA0_HI, 32'h000F_FFFF);
		rd(REG_P_LO, 32'h00FF_FFFA);
		rd(REG_FLAGS, 32'h0000_0040);
		seed = lfsr(seed);
		ptr <= seed[7:0];
		OP_CODE <= LOAD_MOVE_OP_DOUBLE;
		OP_XSEL <= 1'b1;
		OP_YSEL <= 1'b1;
		go(1);
		rd(5'h05, {8'h00, MEM_X_DATA});
		rd(5'h07, {8'h00, MEM_Y_DATA});
		OP_CODE <= LOAD_MOVE_OP_ACC;
		OP_IMM_SHORT <= 1'b1;
		OP_LONG <= 1'b0;
		OP_ACC <= 2'h0;
		OP_IMM <= 16'h0005;
		go(1);
		OP_ACC <= 2'h2;
		OP_IMM <= 16'h0007;
		go(1);
		OP_CODE <= MAX_SELECT_OP;
		OP_ACC <= 2'h0;
		OP_ACC_SRC <= 2'h2;
		go(1);
		ptr <= 8'h3C;
		rd(REG_INDEX, {16'h0000, PREV_ADDR});
		rd(5'h00, 32'h0000_0007);
		rd(REG_FLAGS, 32'h0000_0048);
		OP_CODE <= MIN_SELECT_OP;
		go(1);
		rd(REG_INDEX, 32'h0000_003C);
		rd(REG_FLAGS, 32'h0000_0043);
		check(32'({FLAG_VM1, FLAG_VM0, FLAG_C}), 32'h0000_0001);
		OP_CODE <= LOAD_MOVE_OP_MAC_PROD;
		OP_MAC <= 1'b1;
		OP_MOVE <= MOVE_STORE_PROD;
		exp_q.push_back(32'h00FF_FFFF);
		go(1);
		rd(REG_MA1_HI, 32'h000F_FFFF);
		OP_CODE <= LOAD_MOVE_OP_ACC_MAC;
		OP_ACC <= 2'h1;
		OP_MOVE <= MOVE_MEM_TO_REG;
		OP_REG <= 3'h3;
		go(1);
		rd(5'h01, 32'h00FF_FFFF);
		rd(5'h03, 32'h003C_C33C);
		wr(REG_FLAGS, 32'h0000_0040);
		OP_CODE <= MULTIPLY_ACCUMULATE_OP_MOVE;
		OP_MAC <= 1'b0;
		OP_MOVE <= MAC_HIGH_SHIFT_LEFT;
		OP_ACC <= 2'h3;
		go(1);
		rd(REG_MA0_LO, 32'hFFFF_FFF4);
		rd(5'h03, 32'h00FF_FFFE);
		rd(REG_FLAGS, 32'h0000_0048);
		OP_CODE <= LOAD_MOVE_OP_MAC_MAC;
		go(1);
		rd(REG_MA0_LO, 32'hFFFF_FFFA);
		seed = lfsr(seed);
		ptr <= seed[7:0];
		OP_CODE <= MULTIPLY_ACCUMULATE_OP_DOUBLE;
		go(1);
		rd(5'h07, {8'h00, MEM_Y_DATA});
		{RD, WR} <= 2'b00;
		repeat (2) @(posedge MCLK);
		print_verdict();
	end
endmodule // dlm_datapath_tb_top
